// ---- include/pmsc_pkg.sv ----
// constants, field positions and carrier types for the system control registers
package pmsc_pkg;

	// register offsets on the serial control port
	localparam logic [7:0] PMSC_OFF_SYS_CTRL = 8'h0e;
	localparam logic [7:0] PMSC_OFF_POWER_BEH = 8'h0f;
	localparam logic [7:0] PMSC_OFF_SEQ_SLEW = 8'h10;
	localparam logic [7:0] PMSC_OFF_FLASH_WD = 8'h11;

	// values after reset (fuse defaults stand outside this block)
	localparam logic [7:0] PMSC_RST_SYS_CTRL = 8'h00;
	localparam logic [7:0] PMSC_RST_POWER_BEH = 8'h00;
	localparam logic [7:0] PMSC_RST_SEQ_SLEW = 8'h00;
	localparam logic [7:0] PMSC_RST_FLASH_WD = 8'h00;

	// system control register fields
	localparam int PMSC_SYS_TARGET_BIT = 0;
	localparam int PMSC_SYS_MASK_BIT = 4;

	// power behaviour register fields
	localparam int PMSC_SOFT_START_BIT = 7;
	localparam int PMSC_KEY_LOCK_BIT = 4;
	localparam int PMSC_RST_PD_BIT = 3;
	localparam int PMSC_ABSENT_FLASH_BIT = 2;
	localparam int PMSC_WD_LOWPWR_BIT = 1;
	localparam int PMSC_CHG_SRC_BIT = 0;

	// sequencer, slew and debounce register fields
	localparam int PMSC_DEFAULT_SUPPLY_AT_SLOT0_BIT = 7;
	localparam int PMSC_RAMP_HI = 6;
	localparam int PMSC_RAMP_LO = 5;
	localparam int PMSC_FUSE_RELOAD_BIT = 4;
	localparam int PMSC_AUTO_START_BIT = 3;
	localparam int PMSC_FILTER_HI = 2;
	localparam int PMSC_FILTER_LO = 0;

	// flash and watchdog register fields
	localparam int PMSC_ON_TIME_HI = 7;
	localparam int PMSC_ON_TIME_LO = 6;
	localparam int PMSC_INTERVAL_HI = 5;
	localparam int PMSC_INTERVAL_LO = 3;
	localparam int PMSC_WD_SCALE_HI = 2;
	localparam int PMSC_WD_SCALE_LO = 0;

	// reset event selection that keeps the reset output held
	localparam logic [1:0] PMSC_RST_EVT_HOLD = 2'b11;

	// clock and time bases
	localparam int PMSC_CLK_PERIOD_NS = 5;
	localparam int PMSC_CYC_PER_US = 1000 / PMSC_CLK_PERIOD_NS;
	localparam int PMSC_CNT_W = 32;

	// time per 10 mV ramp step, ns, for codes 00..11
	localparam int PMSC_RAMP_NS [4] = '{4000, 2000, 1000, 500};
	// input filter time, us, for codes 000..111
	localparam int PMSC_FILTER_US [8] = '{0, 100, 1000, 10200, 51200, 256000, 512000, 1024000};
	// flash on-time, us, for codes 00..11 (11 is a double pulse)
	localparam int PMSC_ON_TIME_US [4] = '{10000, 20000, 40000, 20000};
	// double pulse period, us
	localparam int PMSC_DOUBLE_PERIOD_US = 180000;
	// flash interval, us, for codes 000..111 (000 means no flashing)
	localparam int PMSC_INTERVAL_US [8] =
		'{0, 1000000, 2000000, 4000000, 180000, 2000000, 4000000, 180000};

	// flash interval codes from which on the supply start condition gates flashing
	localparam logic [2:0] PMSC_INTERVAL_GATED = 3'b101;

	// request from the serial control port front end
	typedef struct packed {
		logic wr; // one-cycle write strobe
		logic rd; // one-cycle read strobe
		logic [7:0] addr; // register offset
		logic [7:0] wdata; // write data
	} pmsc_req_s;

	// decoded times handed to the sequencer, filters and flash generator
	typedef struct packed {
		logic [PMSC_CNT_W-1:0] ramp_step_cyc; // cycles per 10 mV step
		logic [PMSC_CNT_W-1:0] filter_cyc; // input filter time, 0 means none
		logic [PMSC_CNT_W-1:0] on_time_cyc; // flash on-time
		logic [PMSC_CNT_W-1:0] interval_cyc; // flash interval, 0 means off
		logic double_pulse; // on-time code selects double pulse
		logic [PMSC_CNT_W-1:0] double_period_cyc; // period of the double pulse
	} pmsc_times_s;

endpackage : pmsc_pkg

// ---- rtl/pmsc_time_decode.sv ----
// turns the ramp, filter and flash codes into registered cycle counts
`timescale 1ns/1ps
module pmsc_time_decode #(
	parameter int CYC_PER_US = 200
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [1:0] ramp_code,
	input wire logic [2:0] filter_code,
	input wire logic [1:0] on_time_code,
	input wire logic [2:0] interval_code,
	output pmsc_pkg::pmsc_times_s times
);
	import pmsc_pkg::*;

	pmsc_times_s times_d; // decoded next values
	pmsc_times_s times_q; // registered counts

	// lookups; cycle counts derived from the printed times and the clock rate
	always_comb begin
		times_d = '0;
		times_d.ramp_step_cyc = PMSC_CNT_W'(PMSC_RAMP_NS[ramp_code] / PMSC_CLK_PERIOD_NS);
		times_d.filter_cyc = PMSC_CNT_W'(PMSC_FILTER_US[filter_code] * CYC_PER_US);
		times_d.on_time_cyc = PMSC_CNT_W'(PMSC_ON_TIME_US[on_time_code] * CYC_PER_US);
		times_d.interval_cyc = PMSC_CNT_W'(PMSC_INTERVAL_US[interval_code] * CYC_PER_US);
		times_d.double_pulse = (on_time_code == 2'b11);
		times_d.double_period_cyc = PMSC_CNT_W'(PMSC_DOUBLE_PERIOD_US * CYC_PER_US);
	end

	// register so consumers see stable counts one cycle after the codes change, two after a write
	always_ff @(posedge clk) begin
		if (srst) begin
			times_q <= '0;
		end else begin
			times_q <= times_d;
		end
	end

	assign times = times_q;

endmodule : pmsc_time_decode

// ---- rtl/pmsc_ctrl_regs.sv ----
// system control registers: storage, read port and decoded controls
`timescale 1ns/1ps
module pmsc_ctrl_regs #(
	parameter int CYC_PER_US = pmsc_pkg::PMSC_CYC_PER_US
) (
	input wire logic clk,
	input wire logic srst,
	input pmsc_pkg::pmsc_req_s req,
	output logic [7:0] rdata,
	output logic rvalid,
	input wire logic system_enable_pin,
	input wire logic powerup_seq_active,
	input wire logic low_power_state_start,
	input wire logic low_power_exit,
	input wire logic [1:0] reset_event_sel,
	input wire logic reset_mode_exit,
	input wire logic wake_event,
	input wire logic slot0_entry,
	input wire logic supply_start,
	input wire logic ext_supply_present,
	output logic system_target,
	output logic buck_soft_start,
	output logic key_wake_lock,
	output logic reset_out_n,
	output logic supply_absent_flash,
	output logic watchdog_in_low_power,
	output logic charger_wake_source,
	output logic default_supply_at_slot0,
	output logic fuse_reload_req,
	output logic sequencer_start,
	output logic flash_active,
	output logic watchdog_enable,
	output logic [2:0] watchdog_period_scale,
	output pmsc_pkg::pmsc_times_s times
);
	import pmsc_pkg::*;

	// stored registers; reserved bits are kept as written and drive nothing
	logic [7:0] sys_ctrl_q, sys_ctrl_d; // system control
	logic [7:0] power_beh_q, power_beh_d; // power behaviour
	logic [7:0] seq_slew_q, seq_slew_d; // sequencer, slew, filter
	logic [7:0] flash_wd_q, flash_wd_d; // flash and watchdog
	logic pin_q, pin_d; // previous level of the system enable pin
	// pin_q idles low like the pin, so no false edge follows reset
	// read port
	logic [7:0] rdata_q, rdata_d;
	logic rvalid_q, rvalid_d;
	// event outputs and reset pin state
	logic reset_out_n_q, reset_out_n_d;
	logic fuse_reload_q, fuse_reload_d;
	logic seq_start_q, seq_start_d;
	logic default_supply_at_slot0_q, default_supply_at_slot0_d;
	logic waiting_wake_q, waiting_wake_d; // left reset mode, awaiting a wake
	// level outputs decoded from the registers
	logic soft_start_q, soft_start_d;
	logic absent_flash_q, absent_flash_d;
	logic wd_lowpwr_q, wd_lowpwr_d;
	logic chg_src_q, chg_src_d;
	logic flash_active_q, flash_active_d;
	logic wd_en_q, wd_en_d;
	logic [2:0] wd_scale_q, wd_scale_d;

	// write strobes per register
	// writes to any other offset match no strobe and are dropped
	logic wr_sys, wr_beh, wr_seq, wr_fwd;
	logic [2:0] interval_code; // current flash interval field
	logic [2:0] wd_code; // current watchdog scale field

	assign wr_sys = req.wr && (req.addr == PMSC_OFF_SYS_CTRL);
	assign wr_beh = req.wr && (req.addr == PMSC_OFF_POWER_BEH);
	assign wr_seq = req.wr && (req.addr == PMSC_OFF_SEQ_SLEW);
	assign wr_fwd = req.wr && (req.addr == PMSC_OFF_FLASH_WD);
	assign interval_code = flash_wd_q[PMSC_INTERVAL_HI:PMSC_INTERVAL_LO];
	assign wd_code = flash_wd_q[PMSC_WD_SCALE_HI:PMSC_WD_SCALE_LO];

	// register storage next values
	// each register keeps its value unless written or forced by an event
	always_comb begin
		sys_ctrl_d = sys_ctrl_q;
		power_beh_d = power_beh_q;
		seq_slew_d = seq_slew_q;
		flash_wd_d = flash_wd_q;
		pin_d = system_enable_pin;
		// system control: the mask bit keeps the target bit out of the write
		if (wr_sys) begin
			sys_ctrl_d = req.wdata;
			if (sys_ctrl_q[PMSC_SYS_MASK_BIT]) begin
				sys_ctrl_d[PMSC_SYS_TARGET_BIT] = sys_ctrl_q[PMSC_SYS_TARGET_BIT];
			end
		end
		// a pin edge sets the target to the pin level, last word over a same-cycle write
		if (system_enable_pin != pin_q) begin
			sys_ctrl_d[PMSC_SYS_TARGET_BIT] = system_enable_pin;
		end
		if (wr_beh) begin
			power_beh_d = req.wdata;
		end
		// the power-up sequence drops the lock even against a software set
		if (powerup_seq_active) begin
			power_beh_d[PMSC_KEY_LOCK_BIT] = 1'b0;
		end
		if (wr_seq) begin
			seq_slew_d = req.wdata;
		end
		if (wr_fwd) begin
			flash_wd_d = req.wdata;
		end
	end

	// register storage
	always_ff @(posedge clk) begin
		if (srst) begin
			sys_ctrl_q <= PMSC_RST_SYS_CTRL;
			power_beh_q <= PMSC_RST_POWER_BEH;
			seq_slew_q <= PMSC_RST_SEQ_SLEW;
			flash_wd_q <= PMSC_RST_FLASH_WD;
			pin_q <= 1'b0;
		end else begin
			sys_ctrl_q <= sys_ctrl_d;
			power_beh_q <= power_beh_d;
			seq_slew_q <= seq_slew_d;
			flash_wd_q <= flash_wd_d;
			pin_q <= pin_d;
		end
	end

	// an unmapped read still answers, so the host never waits on a missing pulse
	// read port: data one cycle after the strobe, zero for unmapped offsets
	always_comb begin
		rvalid_d = req.rd;
		rdata_d = 8'h00;
		if (req.rd) begin
			case (req.addr)
				PMSC_OFF_SYS_CTRL: rdata_d = sys_ctrl_q;
				PMSC_OFF_POWER_BEH: rdata_d = power_beh_q;
				PMSC_OFF_SEQ_SLEW: rdata_d = seq_slew_q;
				PMSC_OFF_FLASH_WD: rdata_d = flash_wd_q;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	// read port registers
	// rvalid drops again after one cycle, a single pulse per strobe
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	// sequencing events: reset pin, fuse reload, sequencer start, slot0 defaults
	always_comb begin
		reset_out_n_d = reset_out_n_q;
		// assert before power-down only when enabled; otherwise untouched
		// assert is tested first so it wins over a release in the same cycle
		if (low_power_state_start && power_beh_q[PMSC_RST_PD_BIT]) begin
			reset_out_n_d = 1'b0;
		end else if (low_power_exit && (reset_event_sel < PMSC_RST_EVT_HOLD)) begin
			reset_out_n_d = 1'b1;
		end
		// a release needs no earlier assert; an idle high output simply stays high
		// fuse reload pulse on leaving low power
		fuse_reload_d = low_power_exit && seq_slew_q[PMSC_FUSE_RELOAD_BIT];
		// auto start goes at once; otherwise hold until a wake event
		// waiting_wake remembers a non-auto exit until a wake arrives
		waiting_wake_d = waiting_wake_q;
		seq_start_d = 1'b0;
		if (reset_mode_exit) begin
			if (seq_slew_q[PMSC_AUTO_START_BIT]) begin
				seq_start_d = 1'b1;
				waiting_wake_d = 1'b0;
			end else if (wake_event) begin
				seq_start_d = 1'b1;
				waiting_wake_d = 1'b0;
			end else begin
				waiting_wake_d = 1'b1;
			end
		end else if (waiting_wake_q && wake_event) begin
			seq_start_d = 1'b1;
			waiting_wake_d = 1'b0;
		end
		// slot0 entry applies fuse defaults to all but the core regulator
		default_supply_at_slot0_d = slot0_entry && seq_slew_q[PMSC_DEFAULT_SUPPLY_AT_SLOT0_BIT];
	end

	// sequencing event registers; the reset output idles released
	always_ff @(posedge clk) begin
		if (srst) begin
			reset_out_n_q <= 1'b1;
			fuse_reload_q <= 1'b0;
			seq_start_q <= 1'b0;
			default_supply_at_slot0_q <= 1'b0;
			waiting_wake_q <= 1'b0;
		end else begin
			reset_out_n_q <= reset_out_n_d;
			fuse_reload_q <= fuse_reload_d;
			seq_start_q <= seq_start_d;
			default_supply_at_slot0_q <= default_supply_at_slot0_d;
			waiting_wake_q <= waiting_wake_d;
		end
	end

	// level controls decoded from the register fields
	// levels lag the register by one cycle, the price of flop outputs
	always_comb begin
		soft_start_d = power_beh_q[PMSC_SOFT_START_BIT];
		wd_lowpwr_d = power_beh_q[PMSC_WD_LOWPWR_BIT];
		chg_src_d = power_beh_q[PMSC_CHG_SRC_BIT];
		// timed flashing only while supply start holds and nothing external feeds us
		absent_flash_d = power_beh_q[PMSC_ABSENT_FLASH_BIT] && supply_start
			&& !ext_supply_present;
		// 000 leaves the pins to their mode; high codes wait for supply start
		if (interval_code == 3'b000) begin
			flash_active_d = 1'b0;
		end else if (interval_code >= PMSC_INTERVAL_GATED) begin
			flash_active_d = supply_start;
		end else begin
			flash_active_d = 1'b1;
		end
		// code 000 stops the watchdog; others give a shift of code minus one
		// the watchdog core reads the scale as a shift count: 0 is 1x, 6 is 64x
		wd_en_d = (wd_code != 3'b000);
		wd_scale_d = (wd_code == 3'b000) ? 3'b000 : wd_code - 3'b001;
	end

	// level control registers
	// all levels reset low so nothing downstream acts before software writes
	always_ff @(posedge clk) begin
		if (srst) begin
			soft_start_q <= 1'b0;
			absent_flash_q <= 1'b0;
			wd_lowpwr_q <= 1'b0;
			chg_src_q <= 1'b0;
			flash_active_q <= 1'b0;
			wd_en_q <= 1'b0;
			wd_scale_q <= 3'b000;
		end else begin
			soft_start_q <= soft_start_d;
			absent_flash_q <= absent_flash_d;
			wd_lowpwr_q <= wd_lowpwr_d;
			chg_src_q <= chg_src_d;
			flash_active_q <= flash_active_d;
			wd_en_q <= wd_en_d;
			wd_scale_q <= wd_scale_d;
		end
	end

	// ramp, filter and flash codes become cycle counts
	// the decoder adds one more cycle, so counts settle two cycles after a write
	pmsc_time_decode #(
		.CYC_PER_US(CYC_PER_US)
	) u_time_decode (
		.clk(clk),
		.srst(srst),
		.ramp_code(seq_slew_q[PMSC_RAMP_HI:PMSC_RAMP_LO]),
		.filter_code(seq_slew_q[PMSC_FILTER_HI:PMSC_FILTER_LO]),
		.on_time_code(flash_wd_q[PMSC_ON_TIME_HI:PMSC_ON_TIME_LO]),
		.interval_code(interval_code),
		.times(times)
	);

	// outputs straight from flip-flops
	// key lock is read from its stored bit, which is itself a flop
	assign rdata = rdata_q;
	assign rvalid = rvalid_q;
	assign system_target = sys_ctrl_q[PMSC_SYS_TARGET_BIT];
	assign key_wake_lock = power_beh_q[PMSC_KEY_LOCK_BIT];
	assign buck_soft_start = soft_start_q;
	assign reset_out_n = reset_out_n_q;
	assign supply_absent_flash = absent_flash_q;
	assign watchdog_in_low_power = wd_lowpwr_q;
	assign charger_wake_source = chg_src_q;
	assign default_supply_at_slot0 = default_supply_at_slot0_q;
	assign fuse_reload_req = fuse_reload_q;
	assign sequencer_start = seq_start_q;
	assign flash_active = flash_active_q;
	assign watchdog_enable = wd_en_q;
	assign watchdog_period_scale = wd_scale_q;

endmodule : pmsc_ctrl_regs

// ---- verification/pmsc_sva.sv ----
// port-level assertions for the system control registers
`timescale 1ns/1ps
module pmsc_sva #(
	parameter int CYC_PER_US = 200 // kept equal to the design's, ramp checks do not scale
) (
	input wire logic clk,
	input wire logic srst,
	input pmsc_pkg::pmsc_req_s req,
	input wire logic rvalid,
	input wire logic powerup_seq_active,
	input wire logic low_power_state_start,
	input wire logic low_power_exit,
	input wire logic [1:0] reset_event_sel,
	input wire logic slot0_entry,
	input wire logic buck_soft_start,
	input wire logic key_wake_lock,
	input wire logic reset_out_n,
	input wire logic default_supply_at_slot0,
	input wire logic fuse_reload_req,
	input wire logic watchdog_enable,
	input pmsc_pkg::pmsc_times_s times
);
	import pmsc_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// every read strobe gets its answer one cycle later
	a_read_answered: assert property (req.rd |=> rvalid)
		else $error("read strobe not answered");
	a_soft_start_follows: assert property (req.wr && req.addr == PMSC_OFF_POWER_BEH |->
		##2 buck_soft_start == $past(req.wdata[PMSC_SOFT_START_BIT], 2))
		else $error("soft start does not follow write");
	// a clear from the power-up sequence wins, so only writes outside it are checked
	a_key_lock_write: assert property (req.wr && req.addr == PMSC_OFF_POWER_BEH &&
		!powerup_seq_active |=> key_wake_lock == $past(req.wdata[PMSC_KEY_LOCK_BIT]))
		else $error("key lock not stored");
	a_key_lock_clear: assert property (powerup_seq_active |=> !key_wake_lock)
		else $error("key lock kept during power-up");
	a_reset_cause: assert property ($fell(reset_out_n) |-> $past(low_power_state_start))
		else $error("reset output fell without power-down");
	// the reset-time value must not look like a release
	a_reset_release: assert property ($rose(reset_out_n) && !$past(srst) |->
		$past(low_power_exit) && $past(reset_event_sel) != PMSC_RST_EVT_HOLD)
		else $error("reset output released wrongly");
	a_slot0_cause: assert property (default_supply_at_slot0 |-> $past(slot0_entry))
		else $error("slot 0 default without entry");
	a_fuse_cause: assert property (fuse_reload_req |-> $past(low_power_exit))
		else $error("fuse reload without low power exit");
	a_ramp_decode: assert property (req.wr && req.addr == PMSC_OFF_SEQ_SLEW |->
		##2 times.ramp_step_cyc == (32'd800 >> $past(req.wdata[6:5], 2)))
		else $error("ramp step time wrong");
	a_wd_enable: assert property (req.wr && req.addr == PMSC_OFF_FLASH_WD |->
		##2 watchdog_enable == ($past(req.wdata[2:0], 2) != 3'h0))
		else $error("watchdog enable wrong");
endmodule : pmsc_sva

// ---- verification/pmsc_host.sv ----
// host model on the serial control port: single writes and reads
`timescale 1ns/1ps
module pmsc_host (
	input wire logic clk,
	input wire logic [7:0] rdata,
	input wire logic rvalid,
	output pmsc_pkg::pmsc_req_s req
);
	import pmsc_pkg::*;
	int gap = 0; // idle cycles before a request, raise it for a slow host
	initial req = '{1'b0, 1'b0, 8'h00, 8'h00};
	// one-cycle strobe; released address and data are inverted, never left valid
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		repeat (gap + 1) @(negedge clk);
		req = '{1'b1, 1'b0, a, d};
		@(negedge clk);
		req = '{1'b0, 1'b0, ~a, ~d};
	endtask : write
	// the answer stands for one cycle, so it is taken at the next falling edge
	task automatic read(input logic [7:0] a, output logic [7:0] d, output logic ok);
		repeat (gap + 1) @(negedge clk);
		req = '{1'b0, 1'b1, a, ~req.wdata};
		@(negedge clk);
		req = '{1'b0, 1'b0, ~a, req.wdata};
		d = rdata;
		ok = rvalid;
	endtask : read
endmodule : pmsc_host

// ---- verification/tb_top.sv ----
// self-checking bench for the system control registers
`timescale 1ns/1ps
module tb_top;
	import pmsc_pkg::*;
	localparam int CYC = 1; // short filter and flash counts
	localparam int P_SLOT = 0, P_WAKE = 1, P_RMX = 2, P_LPX = 3, P_PD = 4, P_PU = 5;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic system_enable_pin = 1'b0;
	logic supply_start = 1'b0;
	logic ext_supply_present = 1'b0;
	logic [1:0] reset_event_sel = 2'b00;
	logic [5:0] pls = 6'h00; // one-cycle event inputs
	wire powerup_seq_active, low_power_state_start, low_power_exit;
	wire reset_mode_exit, wake_event, slot0_entry;
	pmsc_req_s req;
	logic [7:0] rdata;
	logic rvalid, system_target, buck_soft_start, key_wake_lock, reset_out_n;
	logic supply_absent_flash, watchdog_in_low_power, charger_wake_source;
	logic default_supply_at_slot0, fuse_reload_req, sequencer_start;
	logic flash_active, watchdog_enable;
	logic [2:0] watchdog_period_scale;
	pmsc_times_s times;
	int mismatches = 0;
	int tests_run = 0;
	int cycles = 0;
	int starts = 0; // sequencer start pulses seen
	assign {powerup_seq_active, low_power_state_start, low_power_exit} = pls[5:3];
	assign {reset_mode_exit, wake_event, slot0_entry} = pls[2:0];
	always #2.5 clk = ~clk;
	pmsc_ctrl_regs #(.CYC_PER_US(CYC)) pmsc_ctrl_regs_inst (.clk, .srst, .req, .rdata, .rvalid,
		.system_enable_pin, .powerup_seq_active, .low_power_state_start, .low_power_exit,
		.reset_event_sel, .reset_mode_exit, .wake_event, .slot0_entry, .supply_start,
		.ext_supply_present, .system_target, .buck_soft_start, .key_wake_lock, .reset_out_n,
		.supply_absent_flash, .watchdog_in_low_power, .charger_wake_source,
		.default_supply_at_slot0, .fuse_reload_req, .sequencer_start, .flash_active,
		.watchdog_enable, .watchdog_period_scale, .times);
	pmsc_host pmsc_host_inst (.clk, .rdata, .rvalid, .req);
	// hang guard, far above the roughly 140 cycles the tests need
	always @(posedge clk) begin
		cycles++;
		starts += int'(sequencer_start === 1'b1);
		if (cycles == 20000) begin
			mismatches++;
			$display("unexpected at %0t: timeout", $time);
			stop_test();
		end
	end
	task automatic stop_test();
		$display("checks %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : stop_test
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h, want %h", $time, got, exp);
		end
	endtask : cmp
	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask : step
	// event pulse; registered answers are settled when it returns
	task automatic pulse(input int b);
		@(negedge clk);
		pls[b] = 1'b1;
		@(negedge clk);
		pls = 6'h00;
	endtask : pulse
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic ok;
		pmsc_host_inst.read(a, d, ok);
		cmp(ok, 1'b1);
		cmp(d, exp);
	endtask : rd_chk
	task automatic t_reset();
		rd_chk(PMSC_OFF_SYS_CTRL, PMSC_RST_SYS_CTRL);
		rd_chk(PMSC_OFF_POWER_BEH, PMSC_RST_POWER_BEH);
		rd_chk(PMSC_OFF_SEQ_SLEW, PMSC_RST_SEQ_SLEW);
		rd_chk(PMSC_OFF_FLASH_WD, PMSC_RST_FLASH_WD);
		pmsc_host_inst.write(8'h12, 8'hff);
		rd_chk(8'h12, 8'h00);
		cmp(reset_out_n, 1'b1);
		$display("test reset done");
	endtask : t_reset
	// mask bit guards the target bit; the pin also sets it
	task automatic t_sys();
		pmsc_host_inst.write(PMSC_OFF_SYS_CTRL, 8'h11);
		step(2);
		cmp(system_target, 1'b1);
		pmsc_host_inst.write(PMSC_OFF_SYS_CTRL, 8'h00);
		step(2);
		cmp(system_target, 1'b1);
		pmsc_host_inst.write(PMSC_OFF_SYS_CTRL, 8'h00);
		step(2);
		cmp(system_target, 1'b0);
		system_enable_pin = 1'b1;
		step(3);
		cmp(system_target, 1'b1);
		$display("test system target done");
	endtask : t_sys
	task automatic t_power();
		pmsc_host_inst.write(PMSC_OFF_POWER_BEH, 8'hff);
		step(2);
		cmp({buck_soft_start, key_wake_lock}, 2'b11);
		cmp({watchdog_in_low_power, charger_wake_source}, 2'b11);
		rd_chk(PMSC_OFF_POWER_BEH, 8'hff);
		supply_start = 1'b1;
		step(3);
		cmp(supply_absent_flash, 1'b1);
		ext_supply_present = 1'b1;
		step(3);
		cmp(supply_absent_flash, 1'b0);
		pulse(P_PD);
		cmp(reset_out_n, 1'b0);
		reset_event_sel = 2'b11;
		pulse(P_LPX);
		cmp(reset_out_n, 1'b0);
		reset_event_sel = 2'b10;
		pulse(P_LPX);
		cmp(reset_out_n, 1'b1);
		pulse(P_PU);
		cmp({key_wake_lock, buck_soft_start}, 2'b01);
		pmsc_host_inst.write(PMSC_OFF_POWER_BEH, 8'h00);
		step(2);
		cmp({buck_soft_start, watchdog_in_low_power, charger_wake_source}, 3'h0);
		pulse(P_PD);
		cmp(reset_out_n, 1'b1);
		$display("test power behaviour done");
	endtask : t_power
	task automatic t_seq();
		int s0;
		pmsc_host_inst.write(PMSC_OFF_SEQ_SLEW, 8'h98);
		step(2);
		pulse(P_SLOT);
		cmp(default_supply_at_slot0, 1'b1);
		pulse(P_LPX);
		cmp(fuse_reload_req, 1'b1);
		s0 = starts;
		pulse(P_RMX);
		step(2);
		cmp(starts - s0, 1);
		pmsc_host_inst.write(PMSC_OFF_SEQ_SLEW, 8'h00);
		step(2);
		pulse(P_SLOT);
		cmp(default_supply_at_slot0, 1'b0);
		pulse(P_LPX);
		cmp(fuse_reload_req, 1'b0);
		s0 = starts;
		pulse(P_RMX);
		step(2);
		cmp(starts - s0, 0);
		pulse(P_WAKE);
		step(2);
		cmp(starts - s0, 1);
		$display("test sequencer done");
	endtask : t_seq
	// every ramp, filter, on-time, interval and scale code
	task automatic t_codes();
		for (int i = 0; i < 8; i++) begin
			supply_start = i[0];
			pmsc_host_inst.write(PMSC_OFF_SEQ_SLEW, {1'b0, i[1:0], 2'b00, i[2:0]});
			pmsc_host_inst.write(PMSC_OFF_FLASH_WD, {i[1:0], i[2:0], i[2:0]});
			step(3);
			cmp(times.ramp_step_cyc, PMSC_RAMP_NS[i[1:0]] / PMSC_CLK_PERIOD_NS);
			cmp(times.filter_cyc, PMSC_FILTER_US[i] * CYC);
			cmp(times.on_time_cyc, PMSC_ON_TIME_US[i[1:0]] * CYC);
			cmp({times.double_pulse}, i[1:0] == 2'b11);
			cmp(times.double_period_cyc, PMSC_DOUBLE_PERIOD_US * CYC);
			cmp(times.interval_cyc, PMSC_INTERVAL_US[i] * CYC);
			cmp(flash_active, i == 0 ? 0 : (i < 5 ? 1 : i[0]));
			cmp(watchdog_enable, i != 0);
			cmp(watchdog_period_scale, i == 0 ? 0 : i - 1);
		end
		$display("test codes done");
	endtask : t_codes
	initial begin
		step(3);
		srst = 1'b0;
		t_reset();
		t_sys();
		t_power();
		t_seq();
		t_codes();
		stop_test();
	end
endmodule : tb_top
bind pmsc_ctrl_regs pmsc_sva #(.CYC_PER_US(CYC_PER_US)) pmsc_sva_inst (.clk, .srst, .req,
	.rvalid, .powerup_seq_active, .low_power_state_start, .low_power_exit, .reset_event_sel,
	.slot0_entry, .buck_soft_start, .key_wake_lock, .reset_out_n, .default_supply_at_slot0,
	.fuse_reload_req, .watchdog_enable, .times);
